// ### logic/pmb_osc_div.sv
// Divider that turns the system clock into an oscillator-rate enable pulse
module pmb_osc_div #(
	parameter int unsigned DIV = pmb_pkg::OSC_DIV
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic run,
	output wire logic tick
);
	localparam logic [7:0] LAST = 8'(DIV - 1);

	typedef struct packed {
		logic [7:0] cnt;
		logic       tick;
	} pmb_div_s;

	pmb_div_s st_ff;
	pmb_div_s nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.tick = 1'b0;
		if (!run) begin
			nxt_st.cnt = 8'h00;
		end else if (st_ff.cnt == LAST) begin
			nxt_st.cnt = 8'h00;
			nxt_st.tick = 1'b1;
		end else begin
			nxt_st.cnt = st_ff.cnt + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tick = st_ff.tick;
endmodule : pmb_osc_div

// ### logic/pmb_power_ctrl.sv
// Power mode sequencer, brownout handling and reset source flags with APB registers

//
// Functional notes
// - Brownout resets by default, optionally raises interrupt
// - Software switch disables brownout reset and interrupt
// - Brownout condition follows supply below trip level
// - Power-up sets power-on flag until cleared
// - Idle, power-down and total power-down states
// - Idle keeps peripherals; exits on reset or interrupt
// - Power-down stops main oscillator and processor clock
// - Power-down exits on reset or wake subset
// - Brownout, watchdog, comparators, clock stay in power-down
// - RC oscillator off unless clock and RTC
// - Total power-down also stops brownout and comparators
// - Power-on sets both flags, clears the rest
// - Writing zero clears a flag, one keeps
// - Enabled external interrupt wakes and resumes
// - Wake holds clock for oscillator cycles plus settling
module pmb_power_ctrl #(
	parameter int unsigned SETTLE_CYC = pmb_pkg::SETTLE_CYC
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output wire logic [31:0] prdata,
	output wire logic        pready,
	output wire logic        pslverr,
	input  wire logic        instr_done,
	input  wire logic [7:0]  irq_src,
	input  wire logic        supply_below,
	input  wire logic        ext_rst_req,
	input  wire logic        wdt_rst_req,
	input  wire logic        sw_rst_req,
	input  wire logic        brk_rst_req,
	output wire logic        cpu_rst,
	output wire logic        cpu_clk_en,
	output wire logic        periph_clk_en,
	output wire logic        main_osc_en,
	output wire logic        rc_osc_en,
	output wire logic        bod_en,
	output wire logic        cmp_en,
	output wire logic        wdt_en,
	output wire logic        rtc_run,
	output wire logic        bo_irq
);
	typedef struct packed {
		pmb_pkg::pmb_state_e state;
		logic                total;
		logic [7:0]          ctrl;
		logic [7:0]          int_en;
		logic [5:0]          reset_source_reg;
		logic                bo_cond;
		logic [31:0]         prdata;
		logic                pready;
		logic                pslverr;
		logic                cpu_rst;
		logic                cpu_clk_en;
		logic                periph_clk_en;
		logic                main_osc_en;
		logic                rc_osc_en;
		logic                bod_en;
		logic                cmp_en;
		logic                wdt_en;
		logic                rtc_run;
		logic                bo_irq;
		logic                wk_start;
		logic                wk_crystal;
	} pmb_ctl_s;

	pmb_ctl_s st_ff;
	pmb_ctl_s nxt_st;

	pmb_wake_if wk ();
	logic       osc_tick;

	pmb_osc_div #(
		.DIV        (pmb_pkg::OSC_DIV)
	) u_div (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.run        (st_ff.main_osc_en),
		.tick       (osc_tick)
	);

	pmb_wake_timer #(
		.SETTLE_CYC (SETTLE_CYC)
	) u_wake (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.osc_tick   (osc_tick),
		.wk         (wk)
	);

	assign wk.start   = st_ff.wk_start;
	assign wk.crystal = st_ff.wk_crystal;

	logic                 acc;
	logic                 mapped;
	logic                 wr_fire;
	logic                 bo_rst;
	logic                 bo_int_ev;
	logic                 rst_ev;
	logic                 idle_hit;
	logic                 pd_hit;
	logic                 in_pd;
	logic                 pd_total;
	logic [5:0]           rst_set;
	logic [1:0]           mode_req;
	pmb_pkg::pmb_status_s stat;

	always_comb begin
		acc = psel && penable;
		mapped = (paddr == pmb_pkg::ADDR_CTRL) || (paddr == pmb_pkg::ADDR_INT_EN) ||
			(paddr == pmb_pkg::ADDR_RESET_SOURCE_REG) || (paddr == pmb_pkg::ADDR_STATUS);
		// Write lands on the edge where pready is seen high
		wr_fire = acc && st_ff.pready && pwrite && mapped;

		bo_rst = st_ff.bo_cond && !st_ff.ctrl[pmb_pkg::CTRL_BO_INT];
		bo_int_ev = st_ff.bo_cond && st_ff.ctrl[pmb_pkg::CTRL_BO_INT];
		rst_ev = ext_rst_req || wdt_rst_req || sw_rst_req || brk_rst_req || bo_rst;
		idle_hit = (|(irq_src & st_ff.int_en)) || bo_int_ev;
		pd_hit = (|(irq_src & st_ff.int_en & pmb_pkg::PD_WAKE_MASK)) || bo_int_ev;

		rst_set = 6'h00;
		rst_set[pmb_pkg::RST_BOF] = bo_rst;
		rst_set[pmb_pkg::RST_EXT] = ext_rst_req;
		rst_set[pmb_pkg::RST_WDT] = wdt_rst_req;
		rst_set[pmb_pkg::RST_SW]  = sw_rst_req;
		rst_set[pmb_pkg::RST_BRK] = brk_rst_req;

		stat = '0;
		stat.state = st_ff.state;
		stat.total = st_ff.total;
		stat.bo_cond = st_ff.bo_cond;
		stat.bod_on = st_ff.bod_en;
		stat.cmp_on = st_ff.cmp_en;
		stat.main_osc = st_ff.main_osc_en;
		stat.rc_osc = st_ff.rc_osc_en;
		stat.wake_busy = wk.busy;
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_st.wk_start = 1'b0;

		// Two-cycle access phase; answer is registered
		nxt_st.pready = acc && !st_ff.pready;
		if (acc && !st_ff.pready) begin
			nxt_st.pslverr = !mapped;
			nxt_st.prdata = 32'h0000_0000;
			if (!pwrite) begin
				case (paddr)
					pmb_pkg::ADDR_CTRL: begin
						nxt_st.prdata = {24'h00_0000, st_ff.ctrl};
					end
					pmb_pkg::ADDR_INT_EN: begin
						nxt_st.prdata = {24'h00_0000, st_ff.int_en};
					end
					pmb_pkg::ADDR_RESET_SOURCE_REG: begin
						nxt_st.prdata = {26'h000_0000, st_ff.reset_source_reg};
					end
					pmb_pkg::ADDR_STATUS: begin
						nxt_st.prdata = stat;
					end
					default: begin
						nxt_st.prdata = 32'h0000_0000;
					end
				endcase
			end
		end else if (!acc) begin
			nxt_st.pslverr = 1'b0;
		end

		if (wr_fire && paddr == pmb_pkg::ADDR_CTRL) begin
			nxt_st.ctrl = pwdata[7:0];
		end
		if (wr_fire && paddr == pmb_pkg::ADDR_INT_EN) begin
			nxt_st.int_en = pwdata[7:0];
		end
		// Hardware set is applied after the clear so a new event is never lost
		if (wr_fire && paddr == pmb_pkg::ADDR_RESET_SOURCE_REG) begin
			nxt_st.reset_source_reg = st_ff.reset_source_reg & pwdata[5:0];
		end
		nxt_st.reset_source_reg = nxt_st.reset_source_reg | rst_set;

		mode_req = nxt_st.ctrl[pmb_pkg::CTRL_MODE_LSB +: 2];

		case (st_ff.state)
			pmb_pkg::ST_RUN: begin
				if (rst_ev) begin
					nxt_st.ctrl[pmb_pkg::CTRL_MODE_LSB +: 2] = pmb_pkg::MODE_RUN;
				end else if (mode_req != pmb_pkg::MODE_RUN) begin
					nxt_st.state = pmb_pkg::ST_PEND;
				end
			end
			pmb_pkg::ST_PEND: begin
				if (rst_ev) begin
					nxt_st.ctrl[pmb_pkg::CTRL_MODE_LSB +: 2] = pmb_pkg::MODE_RUN;
					nxt_st.state = pmb_pkg::ST_RUN;
				end else if (mode_req == pmb_pkg::MODE_RUN) begin
					nxt_st.state = pmb_pkg::ST_RUN;
				end else if (instr_done) begin
					// Entry only once the running instruction has finished
					if (mode_req == pmb_pkg::MODE_IDLE) begin
						nxt_st.state = pmb_pkg::ST_IDLE;
					end else begin
						nxt_st.state = pmb_pkg::ST_PD;
						nxt_st.total = (mode_req == pmb_pkg::MODE_TPD);
					end
				end
			end
			pmb_pkg::ST_IDLE: begin
				if (rst_ev || idle_hit) begin
					nxt_st.ctrl[pmb_pkg::CTRL_MODE_LSB +: 2] = pmb_pkg::MODE_RUN;
					nxt_st.state = pmb_pkg::ST_RUN;
				end
			end
			pmb_pkg::ST_PD: begin
				// Oscillator is stopped, so every exit goes through the wake delay
				if (rst_ev || pd_hit) begin
					nxt_st.ctrl[pmb_pkg::CTRL_MODE_LSB +: 2] = pmb_pkg::MODE_RUN;
					nxt_st.state = pmb_pkg::ST_WAKE;
					nxt_st.total = 1'b0;
					nxt_st.wk_start = 1'b1;
					nxt_st.wk_crystal = st_ff.ctrl[pmb_pkg::CTRL_CLK_XTAL];
				end
			end
			pmb_pkg::ST_WAKE: begin
				if (wk.done) begin
					nxt_st.state = pmb_pkg::ST_RUN;
				end
			end
			default: begin
				nxt_st.state = pmb_pkg::ST_RUN;
				nxt_st.total = 1'b0;
			end
		endcase

		in_pd = (nxt_st.state == pmb_pkg::ST_PD);
		pd_total = in_pd && nxt_st.total;

		nxt_st.cpu_clk_en = (nxt_st.state == pmb_pkg::ST_RUN) ||
			(nxt_st.state == pmb_pkg::ST_PEND);
		nxt_st.periph_clk_en = nxt_st.cpu_clk_en || (nxt_st.state == pmb_pkg::ST_IDLE);
		nxt_st.main_osc_en = !in_pd;
		if (in_pd) begin
			nxt_st.rc_osc_en = nxt_st.ctrl[pmb_pkg::CTRL_CLK_RC] &&
				nxt_st.ctrl[pmb_pkg::CTRL_RTC_EN];
		end else begin
			nxt_st.rc_osc_en = nxt_st.ctrl[pmb_pkg::CTRL_CLK_RC];
		end
		nxt_st.bod_en = nxt_st.ctrl[pmb_pkg::CTRL_BO_EN] && !pd_total;
		nxt_st.cmp_en = !nxt_st.ctrl[pmb_pkg::CTRL_CMP_OFF] && !pd_total;
		nxt_st.wdt_en = 1'b1;
		nxt_st.rtc_run = nxt_st.ctrl[pmb_pkg::CTRL_RTC_EN];

		// Detector output is ignored while the detector is unpowered
		nxt_st.bo_cond = supply_below && st_ff.bod_en;
		nxt_st.bo_irq = bo_int_ev;
		nxt_st.cpu_rst = rst_ev;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_ff <= '0;
			st_ff.state <= pmb_pkg::ST_RUN;
			st_ff.ctrl <= pmb_pkg::CTRL_RESET;
			st_ff.int_en <= pmb_pkg::INT_EN_RESET;
			st_ff.reset_source_reg <= pmb_pkg::RESET_SOURCE_REG_POR;
			st_ff.main_osc_en <= 1'b1;
			st_ff.cpu_clk_en <= 1'b1;
			st_ff.periph_clk_en <= 1'b1;
			st_ff.bod_en <= 1'b1;
			st_ff.cmp_en <= 1'b1;
			st_ff.wdt_en <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign prdata        = st_ff.prdata;
	assign pready        = st_ff.pready;
	assign pslverr       = st_ff.pslverr;
	assign cpu_rst       = st_ff.cpu_rst;
	assign cpu_clk_en    = st_ff.cpu_clk_en;
	assign periph_clk_en = st_ff.periph_clk_en;
	assign main_osc_en   = st_ff.main_osc_en;
	assign rc_osc_en     = st_ff.rc_osc_en;
	assign bod_en        = st_ff.bod_en;
	assign cmp_en        = st_ff.cmp_en;
	assign wdt_en        = st_ff.wdt_en;
	assign rtc_run       = st_ff.rtc_run;
	assign bo_irq        = st_ff.bo_irq;
endmodule : pmb_power_ctrl

// ### logic/pmb_wake_timer.sv
// Wake-up delay: oscillator start-up cycles followed by a settling time
module pmb_wake_timer #(
	parameter int unsigned SETTLE_CYC = pmb_pkg::SETTLE_CYC
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic osc_tick,
	pmb_wake_if.tmr   wk
);
	localparam logic [15:0] SETTLE_LOAD = 16'(SETTLE_CYC);

	typedef struct packed {
		logic        busy;
		logic        settle;
		logic        done;
		logic [9:0]  osc_cnt;
		logic [15:0] set_cnt;
	} pmb_wt_s;

	pmb_wt_s st_ff;
	pmb_wt_s nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		if (wk.start && !st_ff.busy) begin
			nxt_st.busy = 1'b1;
			nxt_st.settle = 1'b0;
			nxt_st.osc_cnt = wk.crystal ? pmb_pkg::WAKE_XTAL_OSC : pmb_pkg::WAKE_RC_OSC;
			nxt_st.set_cnt = SETTLE_LOAD;
		end else if (st_ff.busy && !st_ff.settle) begin
			if (osc_tick) begin
				if (st_ff.osc_cnt <= 10'h001) begin
					nxt_st.settle = 1'b1;
				end else begin
					nxt_st.osc_cnt = st_ff.osc_cnt - 10'h001;
				end
			end
		end else if (st_ff.busy) begin
			// Least settling time, counted in system clocks
			if (st_ff.set_cnt <= 16'h0001) begin
				nxt_st.busy = 1'b0;
				nxt_st.done = 1'b1;
			end else begin
				nxt_st.set_cnt = st_ff.set_cnt - 16'h0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign wk.done = st_ff.done;
	assign wk.busy = st_ff.busy;
endmodule : pmb_wake_timer

// ### shared/pmb_pkg.sv
// Constants, types and register map of the power mode and brownout controller
package pmb_pkg;
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned SETTLE_US     = 60;
	localparam int unsigned SETTLE_CYC    = (SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [9:0]  WAKE_XTAL_OSC = 10'h3e0;
	localparam logic [9:0]  WAKE_RC_OSC   = 10'h0e0;
	localparam int unsigned OSC_DIV       = 17;

	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_INT_EN   = 8'h04;
	localparam logic [7:0]  ADDR_RESET_SOURCE_REG   = 8'h08;
	localparam logic [7:0]  ADDR_STATUS   = 8'h0c;

	localparam int unsigned CTRL_MODE_LSB = 0;
	localparam int unsigned CTRL_BO_EN    = 2;
	localparam int unsigned CTRL_BO_INT   = 3;
	localparam int unsigned CTRL_CMP_OFF  = 4;
	localparam int unsigned CTRL_RTC_EN   = 5;
	localparam int unsigned CTRL_CLK_RC   = 6;
	localparam int unsigned CTRL_CLK_XTAL = 7;
	localparam logic [7:0]  CTRL_RESET    = 8'h04;
	localparam logic [7:0]  INT_EN_RESET  = 8'h00;

	localparam int unsigned RST_POF       = 0;
	localparam int unsigned RST_BOF       = 1;
	localparam int unsigned RST_EXT       = 2;
	localparam int unsigned RST_WDT       = 3;
	localparam int unsigned RST_SW        = 4;
	localparam int unsigned RST_BRK       = 5;
	localparam logic [5:0]  RESET_SOURCE_REG_POR    = 6'h03;

	localparam logic [7:0]  PD_WAKE_MASK  = 8'h0f;

	typedef enum logic [1:0] {
		MODE_RUN  = 2'h0,
		MODE_IDLE = 2'h1,
		MODE_PD   = 2'h2,
		MODE_TPD  = 2'h3
	} pmb_mode_e;

	typedef enum logic [4:0] {
		ST_RUN  = 5'h01,
		ST_PEND = 5'h02,
		ST_IDLE = 5'h04,
		ST_PD   = 5'h08,
		ST_WAKE = 5'h10
	} pmb_state_e;

	typedef struct packed {
		logic [19:0] zero;
		logic        wake_busy;
		logic        rc_osc;
		logic        main_osc;
		logic        cmp_on;
		logic        bod_on;
		logic        bo_cond;
		logic        total;
		pmb_state_e  state;
	} pmb_status_s;
endpackage : pmb_pkg

// ### shared/pmb_wake_if.sv
// Handshake between the mode controller and the wake-up delay timer
interface pmb_wake_if;
	logic start;
	logic crystal;
	logic done;
	logic busy;
	modport ctl (output start, output crystal, input done, input busy);
	modport tmr (input start, input crystal, output done, output busy);
endinterface : pmb_wake_if

// ### testbench/pmb_chk.sv
// Assertion checker for the power mode and brownout controller
module pmb_chk #(
	parameter int unsigned SETTLE_CYC = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic instr_done,
	input wire logic supply_below,
	input wire logic ext_rst_req,
	input wire logic wdt_rst_req,
	input wire logic sw_rst_req,
	input wire logic brk_rst_req,
	input wire logic cpu_rst,
	input wire logic cpu_clk_en,
	input wire logic periph_clk_en,
	input wire logic main_osc_en,
	input wire logic rc_osc_en,
	input wire logic bod_en,
	input wire logic wdt_en,
	input wire logic rtc_run,
	input wire logic bo_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// Divider restarts from zero with the oscillator, yet allow one tick either way
	localparam int LO = 223 * 17 + SETTLE_CYC;
	localparam int HI = 993 * 17 + SETTLE_CYC + 4;
	logic        wake_ff;
	logic [15:0] cnt_ff;
	always_ff @(posedge clk) begin
		wake_ff <= !sys_rst && (wake_ff ? !cpu_clk_en : $rose(main_osc_en));
		cnt_ff  <= wake_ff ? cnt_ff + 16'h1 : 16'h0;
	end
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_brown;
		(supply_below && bod_en) [*2];
	endsequence
	chk_apb_answer: assert property (s_setup |=> !pready ##1 pready)
		else $error("pready not two cycles after setup");
	chk_brown_act: assert property (s_brown |=> cpu_rst || bo_irq)
		else $error("brownout gave neither reset nor irq");
	chk_brown_off: assert property (!bod_en [*3] |-> !bo_irq)
		else $error("brownout irq with detector off");
	chk_brown_cause: assert property (bo_irq |-> $past(supply_below, 2))
		else $error("brownout irq without low supply");
	chk_pd_clocks: assert property (!main_osc_en |-> !cpu_clk_en && !periph_clk_en)
		else $error("clocks run with oscillator stopped");
	chk_wdt_alive: assert property (wdt_en)
		else $error("watchdog disabled");
	chk_rc_gate: assert property (!main_osc_en && !rtc_run |-> !rc_osc_en)
		else $error("rc oscillator on in power-down");
	chk_entry_wait: assert property ($fell(cpu_clk_en) |-> $past(instr_done))
		else $error("mode entered mid-instruction");
	chk_wake_min: assert property (wake_ff && cpu_clk_en |-> cnt_ff >= LO)
		else $error("wake delay too short");
	chk_wake_max: assert property (wake_ff |-> cnt_ff <= HI)
		else $error("wake delay too long");
	chk_reset_follow: assert property (
		ext_rst_req || wdt_rst_req || sw_rst_req || brk_rst_req |=> cpu_rst)
		else $error("reset request not passed on");
endmodule : pmb_chk

bind pmb_power_ctrl pmb_chk #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.clk, .sys_rst, .psel,
	.penable, .pready, .instr_done, .supply_below, .ext_rst_req, .wdt_rst_req, .sw_rst_req,
	.brk_rst_req, .cpu_rst, .cpu_clk_en, .periph_clk_en, .main_osc_en, .rc_osc_en, .bod_en,
	.wdt_en, .rtc_run, .bo_irq);

// ### testbench/pmb_far_side.sv
// Far-side model: instruction stream of the processor and supply monitor
module pmb_far_side #(
	parameter logic [11:0] TRIP_MV = 12'ha8c
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        cpu_clk_en,
	input  wire logic [11:0] vdd_mv,
	output var  logic        instr_done,
	output wire logic        supply_below
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] ph_ff;
	// Instructions only retire while the processor clock runs
	always_ff @(posedge clk) begin
		ph_ff      <= sys_rst ? 2'h0 : ph_ff + 2'h1;
		instr_done <= !sys_rst && cpu_clk_en && ph_ff == 2'h3;
	end
	assign supply_below = vdd_mv < TRIP_MV;
endmodule : pmb_far_side

// ### testbench/testbench.sv
// Self-checking bench for the power mode and brownout controller
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned SC = 8;
	localparam logic [11:0] VHI = 12'hce4;
	localparam logic [11:0] VLO = 12'h7d0;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, instr_done, supply_below;
	logic [7:0]  irq_src = 8'h00;
	logic [3:0]  rst_req = 4'h0;
	logic [11:0] vdd_mv = VHI;
	logic        cpu_rst, cpu_clk_en, periph_clk_en, main_osc_en, rc_osc_en;
	logic        bod_en, cmp_en, wdt_en, rtc_run, bo_irq;
	int          n_fail = 0, tests_run = 0;
	always #2.5 clk = ~clk;
	pmb_power_ctrl #(.SETTLE_CYC(SC)) dut (.clk, .sys_rst, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .instr_done, .irq_src, .supply_below,
		.ext_rst_req(rst_req[0]), .wdt_rst_req(rst_req[1]), .sw_rst_req(rst_req[2]),
		.brk_rst_req(rst_req[3]), .cpu_rst, .cpu_clk_en, .periph_clk_en, .main_osc_en,
		.rc_osc_en, .bod_en, .cmp_en, .wdt_en, .rtc_run, .bo_irq);
	pmb_far_side far (.clk, .sys_rst, .cpu_clk_en, .vdd_mv, .instr_done, .supply_below);
	task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_reg
	task automatic check_bit(input logic got, input logic exp);
		check_reg({31'h0, got}, {31'h0, exp});
	endtask : check_bit
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask : cyc
	// Idle edge first so release and next setup never share a time step
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		psel    <= 1'b1;
		penable <= 1'b0;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			check_bit(1'b0, 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0);
		check_reg(rd, exp);
	endtask : rd_chk
	task automatic wait_clk(input logic v, output int n);
		n = 0;
		while (cpu_clk_en !== v && n < 40000) begin
			@(posedge clk);
			n++;
		end
		check_bit(cpu_clk_en, v);
	endtask : wait_clk
	task automatic pulse(input int i);
		@(posedge clk);
		rst_req[i] <= 1'b1;
		@(posedge clk);
		rst_req[i] <= 1'b0;
	endtask : pulse
	task automatic brown(input logic [11:0] v, input logic r, input logic q);
		vdd_mv <= v;
		cyc(4);
		check_bit(cpu_rst, r);
		check_bit(bo_irq, q);
	endtask : brown
	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		cyc(60000);
		n_fail++;
		tally_and_finish();
	end
	initial begin
		int n;
		cyc(12);
		sys_rst <= 1'b0;
		rd_chk(8'h00, 32'h04);
		rd_chk(8'h04, 32'h00);
		rd_chk(8'h08, 32'h03);
		rd_chk(8'h0c, 32'h381);
		rd_chk(8'h10, 32'h00);
		check_bit(err, 1'b1);
		apb(8'h08, 1'b1, 32'h02);
		rd_chk(8'h08, 32'h02);
		apb(8'h08, 1'b1, 32'h3f);
		rd_chk(8'h08, 32'h02);
		apb(8'h08, 1'b1, 32'h00);
		for (int i = 0; i < 4; i++) begin
			pulse(i);
			rd_chk(8'h08, ((32'h2 << i) - 32'h1) << 2);
		end
		sys_rst <= 1'b1;
		cyc(2);
		sys_rst <= 1'b0;
		rd_chk(8'h08, 32'h03);
		apb(8'h08, 1'b1, 32'h00);
		vdd_mv <= VLO;
		cyc(4);
		check_bit(cpu_rst, 1'b1);
		rd_chk(8'h0c, 32'h3c1);
		brown(VHI, 1'b0, 1'b0);
		rd_chk(8'h08, 32'h02);
		apb(8'h00, 1'b1, 32'h0c);
		brown(VLO, 1'b0, 1'b1);
		brown(VHI, 1'b0, 1'b0);
		apb(8'h00, 1'b1, 32'h08);
		brown(VLO, 1'b0, 1'b0);
		brown(VHI, 1'b0, 1'b0);
		// Idle: only an enabled source may end it
		apb(8'h04, 1'b1, 32'h80);
		apb(8'h00, 1'b1, 32'h05);
		wait_clk(1'b0, n);
		check_bit(periph_clk_en, 1'b1);
		check_bit(main_osc_en, 1'b1);
		rd_chk(8'h0c, 32'h384);
		irq_src <= 8'h40;
		cyc(10);
		check_bit(cpu_clk_en, 1'b0);
		irq_src <= 8'h80;
		wait_clk(1'b1, n);
		irq_src <= 8'h00;
		rd_chk(8'h00, 32'h04);
		// Power-down on rc with clock kept, comparators off
		apb(8'h04, 1'b1, 32'h81);
		apb(8'h00, 1'b1, 32'h76);
		wait_clk(1'b0, n);
		cyc(2);
		check_reg({main_osc_en, rc_osc_en, bod_en, cmp_en, wdt_en, rtc_run}, 32'h1b);
		irq_src <= 8'h80;
		cyc(20);
		check_bit(main_osc_en, 1'b0);
		irq_src <= 8'h81;
		wait_clk(1'b1, n);
		check_bit(n >= 223 * 17 + SC && n <= 225 * 17 + SC + 6, 1'b1);
		irq_src <= 8'h00;
		// Total power-down on crystal, supply sagging meanwhile
		apb(8'h00, 1'b1, 32'hc7);
		wait_clk(1'b0, n);
		cyc(2);
		check_reg({main_osc_en, rc_osc_en, bod_en, cmp_en, wdt_en, rtc_run}, 32'h02);
		brown(VLO, 1'b0, 1'b0);
		brown(VHI, 1'b0, 1'b0);
		pulse(0);
		wait_clk(1'b1, n);
		check_bit(n >= 991 * 17 + SC && n <= 993 * 17 + SC + 6, 1'b1);
		check_bit(bod_en, 1'b1);
		tally_and_finish();
	end
endmodule : testbench
